// ==== shared/status_service_pkg.sv ====
/*
 * Constants for the status and service request unit: summary byte
 * bit positions, event register bit positions, used-bit masks, reset
 * values and the selector codes of the register access port.
 * Assumes a command parser on the same clock that decodes the
 * instrument commands into selector codes and one-cycle strobes.
 */
package status_service_pkg;

    localparam int SUM_W = 8;
    localparam int EV_W  = 16;
    localparam int SEL_W = 4;

    // summary byte bit positions
    localparam int STB_MEAS = 0;
    localparam int STB_ERR  = 2;
    localparam int STB_QUES = 3;
    localparam int STB_MSG  = 4;
    localparam int STB_STD  = 5;
    localparam int STB_REQ  = 6;
    localparam int STB_OPER = 7;

    // standard event bits
    localparam int SE_OPC       = 0;
    localparam int SE_QUERY     = 2;
    localparam int SE_INTERNAL  = 3;
    localparam int SE_EXECUTION = 4;
    localparam int SE_COMMAND   = 5;
    localparam int SE_USER      = 6;
    localparam int SE_POWER     = 7;

    // operation event bits
    localparam int OP_CAL  = 0;
    localparam int OP_TRIG = 5;
    localparam int OP_IDLE = 10;

    // measurement event bits
    localparam int ME_INTERLOCK  = 1;
    localparam int ME_LASER_OVF  = 2;
    localparam int ME_DET1_OVF   = 3;
    localparam int ME_DET2_OVF   = 4;
    localparam int ME_READING    = 6;
    localparam int ME_SWEEP_ABRT = 7;
    localparam int ME_SWEEP_DONE = 8;
    localparam int ME_OVER_TEMP  = 12;
    localparam int ME_COMPLIANCE = 14;

    // questionable event bits
    localparam int QU_CAL  = 8;
    localparam int QU_WARN = 14;

    // bits that exist in each event register; the rest read as zero
    localparam logic [SUM_W-1:0] SE_USED  = 8'hfd;
    localparam logic [EV_W-1:0]  OP_USED  = 16'h0421;
    localparam logic [EV_W-1:0]  ME_USED  = 16'h51de;
    localparam logic [EV_W-1:0]  QU_USED  = 16'h4100;
    // calibration fault survives reads and clears
    localparam logic [EV_W-1:0]  QU_STICKY = 16'h0100;

    localparam logic [SUM_W-1:0] SE_RESET  = 8'h80;
    localparam logic [SUM_W-1:0] SUM_ZERO  = 8'h00;
    localparam logic [EV_W-1:0]  EV_ZERO   = 16'h0000;

    // register access selector codes
    localparam logic [SEL_W-1:0] SEL_STB     = 4'h0;
    localparam logic [SEL_W-1:0] SEL_SRE     = 4'h1;
    localparam logic [SEL_W-1:0] SEL_ESR     = 4'h2;
    localparam logic [SEL_W-1:0] SEL_ESE     = 4'h3;
    localparam logic [SEL_W-1:0] SEL_OPER_EV = 4'h4;
    localparam logic [SEL_W-1:0] SEL_OPER_EN = 4'h5;
    localparam logic [SEL_W-1:0] SEL_MEAS_EV = 4'h6;
    localparam logic [SEL_W-1:0] SEL_MEAS_EN = 4'h7;
    localparam logic [SEL_W-1:0] SEL_QUES_EV = 4'h8;
    localparam logic [SEL_W-1:0] SEL_QUES_EN = 4'h9;

    typedef enum logic {POLL_IDLE, POLL_ACTIVE} poll_state_e;

endpackage : status_service_pkg

// ==== rtl/status_service_request_unit.sv ====
/*
 * Status reporting and service request logic: four latched event
 * registers with enables, the summary byte, the request enable mask,
 * the request-service flag and the serial poll answer.
 * Assumes command strobes come from logic on clk; only the interlock
 * pin arrives from outside and is synchronised here.
 */
// Operation
// - enabled summary rise sets request flag
// - finished serial poll clears request flag
// - same event may request again later
// - poll keeps master summary; follows summaries
// - poll answers summary byte between enable/disable
// - eight-bit request enable, write and readback
// - writing zero clears request enable
// - clear and preset keep request enable
// - enabled error availability raises master summary
// - operation complete only from completion query
// - read on empty output queue: query error
// - internal, execution, command error bits; B1 unused
// - syntax, semantic, trigger-in-message set command error
// - local key sets user request
// - power restore sets power-on flag
// - operation bits: calibrating, trigger wait, idle
// - interlock low sets measurement bit one
// - three measurement overflow bits
// - reading available, sweep aborted, sweep done
// - over temperature and source compliance bits
// - calibration fault cleared only by calibration
// - ignored parameter sets command warning
// - AND with enable, OR drives bit six
// - summary bits follow sources unlatched
// - events latch; read and clear clear all but calibration fault
// - masked event bits form set summary
`timescale 1ns/1ns
module status_service_request_unit
(
    input  wire logic                                 clk,
    input  wire logic                                 nrst,
    // register access port
    input  wire logic                                 write_req,
    input  wire logic [status_service_pkg::SEL_W-1:0] write_sel,
    input  wire logic [status_service_pkg::EV_W-1:0]  write_data,
    input  wire logic                                 read_req,
    input  wire logic [status_service_pkg::SEL_W-1:0] read_sel,
    input  wire logic                                 clear_status,
    input  wire logic                                 status_preset,
    output logic      [status_service_pkg::EV_W-1:0]  read_data,
    output logic                                      read_valid,
    // queue levels
    input  wire logic                                 error_available,
    input  wire logic                                 message_available,
    input  wire logic                                 talk_attempt,
    // standard events
    input  wire logic                                 opc_query_done,
    input  wire logic                                 internal_fault_error,
    input  wire logic                                 execution_error,
    input  wire logic                                 syntax_error,
    input  wire logic                                 semantic_error,
    input  wire logic                                 trigger_in_message,
    input  wire logic                                 user_request,
    // operation events
    input  wire logic                                 calibrating,
    input  wire logic                                 trigger_link_wait,
    input  wire logic                                 idle_state,
    // measurement events
    input  wire logic                                 interlock_n,
    input  wire logic                                 laser_voltage_overflow,
    input  wire logic                                 detector_one_overflow,
    input  wire logic                                 detector_two_overflow,
    input  wire logic                                 reading_available,
    input  wire logic                                 sweep_aborted,
    input  wire logic                                 sweep_done,
    input  wire logic                                 over_temperature,
    input  wire logic                                 source_compliance,
    // questionable events
    input  wire logic                                 cal_constant_invalid,
    input  wire logic                                 calibration_passed,
    input  wire logic                                 command_warning,
    // serial poll
    input  wire logic                                 serial_poll_enable,
    input  wire logic                                 serial_poll_disable,
    input  wire logic                                 poll_byte_taken,
    output logic      [status_service_pkg::SUM_W-1:0] poll_byte,
    output logic      [status_service_pkg::SUM_W-1:0] status_byte,
    output logic                                      service_request,
    output logic                                      poll_active
);
    import status_service_pkg::*;

    // clear wins only where no event arrives in the same cycle
    function automatic logic [EV_W-1:0] latch_next
    (
        input logic [EV_W-1:0] q,
        input logic [EV_W-1:0] set,
        input logic [EV_W-1:0] clr
    );
        latch_next = (q & ~clr) | set;
    endfunction : latch_next

    logic [SUM_W-1:0] std_ev_q;
    logic [SUM_W-1:0] std_en_q;
    logic [EV_W-1:0]  oper_ev_q;
    logic [EV_W-1:0]  oper_en_q;
    logic [EV_W-1:0]  meas_ev_q;
    logic [EV_W-1:0]  meas_en_q;
    logic [EV_W-1:0]  ques_ev_q;
    logic [EV_W-1:0]  ques_en_q;
    logic [SUM_W-1:0] request_enable_q;
    logic [SUM_W-1:0] enabled_prev_q;
    logic             request_service_flag_q;
    logic [SUM_W-1:0] status_byte_q;
    logic [SUM_W-1:0] poll_byte_q;
    logic [EV_W-1:0]  read_data_q;
    logic             read_valid_q;
    logic             interlock_meta_q;
    logic             interlock_sync_q;
    poll_state_e      poll_state_q;

    logic [EV_W-1:0]  std_set;
    logic [EV_W-1:0]  oper_set;
    logic [EV_W-1:0]  meas_set;
    logic [EV_W-1:0]  ques_set;
    logic [EV_W-1:0]  std_clr;
    logic [EV_W-1:0]  oper_clr;
    logic [EV_W-1:0]  meas_clr;
    logic [EV_W-1:0]  ques_clr;
    logic [EV_W-1:0]  std_next;
    logic [SUM_W-1:0] summary_d;
    logic [SUM_W-1:0] enabled_d;
    logic             poll_done;
    logic             enable_preset;

    assign poll_done     = (poll_state_q == POLL_ACTIVE) && poll_byte_taken;
    assign enable_preset = status_preset;

    // interlock pin is asynchronous to clk
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            interlock_meta_q <= 1'b1;
            interlock_sync_q <= 1'b1;
        end
        else
        begin
            interlock_meta_q <= interlock_n;
            interlock_sync_q <= interlock_meta_q;
        end
    end

    always_comb
    begin
        std_set               = EV_ZERO;
        std_set[SE_OPC]       = opc_query_done;
        std_set[SE_QUERY]     = talk_attempt && !message_available;
        std_set[SE_INTERNAL]  = internal_fault_error;
        std_set[SE_EXECUTION] = execution_error;
        std_set[SE_COMMAND]   = syntax_error || semantic_error || trigger_in_message;
        std_set[SE_USER]      = user_request;

        oper_set          = EV_ZERO;
        oper_set[OP_CAL]  = calibrating;
        oper_set[OP_TRIG] = trigger_link_wait;
        oper_set[OP_IDLE] = idle_state;

        meas_set                = EV_ZERO;
        meas_set[ME_INTERLOCK]  = !interlock_sync_q;
        meas_set[ME_LASER_OVF]  = laser_voltage_overflow;
        meas_set[ME_DET1_OVF]   = detector_one_overflow;
        meas_set[ME_DET2_OVF]   = detector_two_overflow;
        meas_set[ME_READING]    = reading_available;
        meas_set[ME_SWEEP_ABRT] = sweep_aborted;
        meas_set[ME_SWEEP_DONE] = sweep_done;
        meas_set[ME_OVER_TEMP]  = over_temperature;
        meas_set[ME_COMPLIANCE] = source_compliance;

        ques_set          = EV_ZERO;
        ques_set[QU_CAL]  = cal_constant_invalid;
        ques_set[QU_WARN] = command_warning;
    end

    always_comb
    begin
        std_clr  = {EV_W{clear_status || (read_req && read_sel == SEL_ESR)}};
        oper_clr = {EV_W{clear_status || (read_req && read_sel == SEL_OPER_EV)}};
        meas_clr = {EV_W{clear_status || (read_req && read_sel == SEL_MEAS_EV)}};
        ques_clr = {EV_W{clear_status || (read_req && read_sel == SEL_QUES_EV)}}
                   & ~QU_STICKY;
        if (calibration_passed)
            ques_clr = ques_clr | QU_STICKY;
        std_next = latch_next({{(EV_W-SUM_W){1'b0}}, std_ev_q}, std_set, std_clr);
    end

    // event latches; power-on flag is set out of reset
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            std_ev_q  <= SE_RESET;
            oper_ev_q <= EV_ZERO;
            meas_ev_q <= EV_ZERO;
            ques_ev_q <= EV_ZERO;
        end
        else
        begin
            std_ev_q  <= std_next[SUM_W-1:0] & SE_USED;
            oper_ev_q <= latch_next(oper_ev_q, oper_set, oper_clr) & OP_USED;
            meas_ev_q <= latch_next(meas_ev_q, meas_set, meas_clr) & ME_USED;
            ques_ev_q <= latch_next(ques_ev_q, ques_set, ques_clr) & QU_USED;
        end
    end

    // event enables; clear_status leaves them alone
    always_ff @(posedge clk)
    begin
        if (!nrst || enable_preset)
        begin
            std_en_q  <= SUM_ZERO;
            oper_en_q <= EV_ZERO;
            meas_en_q <= EV_ZERO;
            ques_en_q <= EV_ZERO;
        end
        else if (write_req)
        begin
            if (write_sel == SEL_ESE)
                std_en_q <= write_data[SUM_W-1:0];
            else if (write_sel == SEL_OPER_EN)
                oper_en_q <= write_data;
            else if (write_sel == SEL_MEAS_EN)
                meas_en_q <= write_data;
            else if (write_sel == SEL_QUES_EN)
                ques_en_q <= write_data;
        end
    end

    // request enable: only power-up or an explicit write changes it
    always_ff @(posedge clk)
    begin
        if (!nrst)
            request_enable_q <= SUM_ZERO;
        else if (write_req && write_sel == SEL_SRE)
            request_enable_q <= write_data[SUM_W-1:0];
    end

    always_comb
    begin
        summary_d           = SUM_ZERO;
        summary_d[STB_MEAS] = |(meas_ev_q & meas_en_q);
        summary_d[STB_ERR]  = error_available;
        summary_d[STB_QUES] = |(ques_ev_q & ques_en_q);
        summary_d[STB_MSG]  = message_available;
        summary_d[STB_STD]  = |(std_ev_q & std_en_q);
        summary_d[STB_OPER] = |(oper_ev_q & oper_en_q);
        enabled_d           = summary_d & request_enable_q;
    end

    // request flag: a fresh rise wins over a poll finishing in the same cycle
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            request_service_flag_q <= 1'b0;
            enabled_prev_q         <= SUM_ZERO;
        end
        else
        begin
            enabled_prev_q <= enabled_d;
            if (|(enabled_d & ~enabled_prev_q))
                request_service_flag_q <= 1'b1;
            else if (poll_done)
                request_service_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            poll_state_q <= POLL_IDLE;
        else
        begin
            case (poll_state_q)
                POLL_IDLE:
                    if (serial_poll_enable)
                        poll_state_q <= POLL_ACTIVE;
                POLL_ACTIVE:
                    if (serial_poll_disable)
                        poll_state_q <= POLL_IDLE;
                default:
                    poll_state_q <= POLL_IDLE;
            endcase
        end
    end

    // two views of bit six: request flag for the poll, master summary for queries
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            status_byte_q <= SUM_ZERO;
            poll_byte_q   <= SUM_ZERO;
        end
        else
        begin
            status_byte_q          <= summary_d;
            status_byte_q[STB_REQ] <= |enabled_d;
            poll_byte_q            <= summary_d;
            if (|(enabled_d & ~enabled_prev_q))
                poll_byte_q[STB_REQ] <= 1'b1;
            else
                poll_byte_q[STB_REQ] <= request_service_flag_q && !poll_done;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            read_data_q  <= EV_ZERO;
            read_valid_q <= 1'b0;
        end
        else
        begin
            read_valid_q <= read_req;
            if (!read_req)
                read_data_q <= EV_ZERO;
            else if (read_sel == SEL_STB)
                read_data_q <= {{(EV_W-SUM_W){1'b0}}, status_byte_q};
            else if (read_sel == SEL_SRE)
                read_data_q <= {{(EV_W-SUM_W){1'b0}}, request_enable_q};
            else if (read_sel == SEL_ESR)
                read_data_q <= {{(EV_W-SUM_W){1'b0}}, std_ev_q};
            else if (read_sel == SEL_ESE)
                read_data_q <= {{(EV_W-SUM_W){1'b0}}, std_en_q};
            else if (read_sel == SEL_OPER_EV)
                read_data_q <= oper_ev_q;
            else if (read_sel == SEL_OPER_EN)
                read_data_q <= oper_en_q;
            else if (read_sel == SEL_MEAS_EV)
                read_data_q <= meas_ev_q;
            else if (read_sel == SEL_MEAS_EN)
                read_data_q <= meas_en_q;
            else if (read_sel == SEL_QUES_EV)
                read_data_q <= ques_ev_q;
            else if (read_sel == SEL_QUES_EN)
                read_data_q <= ques_en_q;
            else
                read_data_q <= EV_ZERO;
        end
    end

    assign read_data       = read_data_q;
    assign read_valid      = read_valid_q;
    assign status_byte     = status_byte_q;
    assign poll_byte       = poll_byte_q;
    assign service_request = request_service_flag_q;
    assign poll_active     = (poll_state_q == POLL_ACTIVE);

endmodule : status_service_request_unit

// ==== dv/serial_poll_ctrl.sv ====
/*
 * Serial poll controller model: enable, take the poll byte, disable.
 * Assumes the unit samples its poll inputs on the rising edge of clk.
 */
`timescale 1ns/1ns
module serial_poll_ctrl
(
    input  wire logic       clk,
    input  wire logic       poll_go,
    input  wire logic       poll_active,
    input  wire logic [7:0] poll_byte,
    output logic            serial_poll_enable,
    output logic            serial_poll_disable,
    output logic            poll_byte_taken,
    output logic            poll_done,
    output logic [7:0]      got
);
    logic [2:0] step = 3'h0;

    initial
    begin
        serial_poll_enable = 1'b0;
        serial_poll_disable = 1'b0;
        poll_byte_taken = 1'b0;
        poll_done = 1'b0;
        got = 8'h00;
    end

    // the byte is taken only once poll mode shows; done holds until the bench lets go
    always @(posedge clk)
    begin
        case (step)
            3'h0:
            begin
                serial_poll_enable <= poll_go;
                step <= poll_go ? 3'h1 : 3'h0;
            end
            3'h1:
            begin
                serial_poll_enable <= 1'b0;
                poll_byte_taken <= poll_active;
                step <= poll_active ? 3'h2 : 3'h1;
            end
            3'h2:
            begin
                poll_byte_taken <= 1'b0;
                got <= poll_byte;
                serial_poll_disable <= 1'b1;
                step <= 3'h3;
            end
            3'h3:
            begin
                serial_poll_disable <= 1'b0;
                poll_done <= 1'b1;
                step <= 3'h4;
            end
            default:
            begin
                poll_done <= poll_go;
                step <= poll_go ? 3'h4 : 3'h0;
            end
        endcase
    end
endmodule : serial_poll_ctrl

// ==== dv/status_service_chk.sv ====
/*
 * Assertions on the ports of the status and service request unit.
 * Assumes one clock and the synchronous active-low reset.
 */
`timescale 1ns/1ns
module status_service_chk
(
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        write_req,
    input wire logic [3:0]  write_sel,
    input wire logic [15:0] write_data,
    input wire logic        read_req,
    input wire logic [3:0]  read_sel,
    input wire logic [15:0] read_data,
    input wire logic        read_valid,
    input wire logic        serial_poll_enable,
    input wire logic        poll_byte_taken,
    input wire logic [7:0]  poll_byte,
    input wire logic [7:0]  status_byte,
    input wire logic        service_request,
    input wire logic        poll_active
);
    import status_service_pkg::*;
    logic [7:0] sre_h;
    logic       sre_chg;

    // summary relations pause for two cycles after an enable write
    always_ff @(posedge clk)
    begin
        sre_chg <= write_req && write_sel == SEL_SRE;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            sre_h <= SUM_ZERO;
        else if (write_req && write_sel == SEL_SRE)
            sre_h <= write_data[7:0];
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_poll_enter;
        serial_poll_enable ##1 poll_active;
    endsequence
    sequence s_take;
        poll_active && poll_byte_taken && !write_req && !sre_chg;
    endsequence

    property p_req_line;
        service_request == poll_byte[STB_REQ];
    endproperty
    a_req_line: assert property (p_req_line) else $error("request line off flag");
    property p_master;
        !sre_chg && !$past(sre_chg) |-> status_byte[STB_REQ] == |(status_byte & sre_h & 8'hbf);
    endproperty
    a_master: assert property (p_master) else $error("summary bit six wrong");
    property p_rise;
        !sre_chg && !$past(sre_chg) && |(status_byte & ~$past(status_byte) & sre_h & 8'hbf)
            |-> service_request;
    endproperty
    a_rise: assert property (p_rise) else $error("rise did not request");
    property p_byte;
        (poll_byte & 8'hbf) == (status_byte & 8'hbf);
    endproperty
    a_byte: assert property (p_byte) else $error("poll byte differs");
    property p_poll_mode;
        serial_poll_enable |-> s_poll_enter;
    endproperty
    a_poll_mode: assert property (p_poll_mode) else $error("poll mode not entered");
    property p_poll_clear;
        s_take |=> !service_request || status_byte != $past(status_byte);
    endproperty
    a_poll_clear: assert property (p_poll_clear) else $error("poll kept flag");
    property p_sre_rd;
        read_req && read_sel == SEL_SRE && !write_req
            |=> read_valid && read_data == {8'h00, $past(sre_h)};
    endproperty
    a_sre_rd: assert property (p_sre_rd) else $error("enable readback wrong");
    property p_refused;
        read_req && read_sel > SEL_QUES_EN |=> read_valid && read_data == EV_ZERO;
    endproperty
    a_refused: assert property (p_refused) else $error("unmapped read not zero");
endmodule : status_service_chk

bind status_service_request_unit status_service_chk u_chk
(
    .clk, .nrst, .write_req, .write_sel, .write_data, .read_req, .read_sel, .read_data,
    .read_valid, .serial_poll_enable, .poll_byte_taken, .poll_byte, .status_byte,
    .service_request, .poll_active
);

// ==== dv/tb_status_service_request_unit.sv ====
/*
 * Bench for the status unit: register tasks, an event table, serial polls.
 * Assumes the poll controller model and the bound checker.
 */
`timescale 1ns/1ns
module tb_status_service_request_unit;
    import status_service_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, write_req = 1'b0, read_req = 1'b0, read_valid;
    logic clear_status = 1'b0, status_preset = 1'b0, calibration_passed = 1'b0;
    logic error_available = 1'b0, message_available = 1'b0, poll_go = 1'b0, poll_done;
    logic serial_poll_enable, serial_poll_disable, poll_byte_taken, poll_active;
    logic service_request;
    logic [3:0] write_sel = 4'h0, read_sel = 4'h0, esel;
    logic [15:0] write_data = 16'h0000, read_data, eexp;
    logic [7:0] poll_byte, status_byte, got;
    logic [21:0] ev = 22'h00_0000;
    int fail_count = 0;
    int comparisons = 0;
    // latch position of each event input, in ev order
    int pos [22] = '{0, 3, 4, 5, 5, 5, 6, 2, 0, 5, 10, 1, 2, 3, 4, 6, 7, 8, 12, 14, 8, 14};

    always #4 clk = ~clk;

    status_service_request_unit dut
    (
        .clk, .nrst, .write_req, .write_sel, .write_data, .read_req, .read_sel, .clear_status,
        .status_preset, .read_data, .read_valid, .error_available, .message_available,
        .talk_attempt(ev[7]), .opc_query_done(ev[0]), .internal_fault_error(ev[1]),
        .execution_error(ev[2]), .syntax_error(ev[3]), .semantic_error(ev[4]),
        .trigger_in_message(ev[5]), .user_request(ev[6]), .calibrating(ev[8]),
        .trigger_link_wait(ev[9]), .idle_state(ev[10]), .interlock_n(!ev[11]),
        .laser_voltage_overflow(ev[12]), .detector_one_overflow(ev[13]),
        .detector_two_overflow(ev[14]), .reading_available(ev[15]), .sweep_aborted(ev[16]),
        .sweep_done(ev[17]), .over_temperature(ev[18]), .source_compliance(ev[19]),
        .cal_constant_invalid(ev[20]), .calibration_passed, .command_warning(ev[21]),
        .serial_poll_enable, .serial_poll_disable, .poll_byte_taken, .poll_byte, .status_byte,
        .service_request, .poll_active
    );

    serial_poll_ctrl host
    (
        .clk, .poll_go, .poll_active, .poll_byte, .serial_poll_enable, .serial_poll_disable,
        .poll_byte_taken, .poll_done, .got
    );

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic wr(input logic [3:0] sel, input logic [15:0] d);
        write_req = 1'b1;
        write_sel = sel;
        write_data = d;
        tick(1);
        write_req = 1'b0;
        tick(1);
    endtask : wr

    task automatic rd(input logic [3:0] sel, input logic [15:0] exp);
        read_req = 1'b1;
        read_sel = sel;
        tick(1);
        read_req = 1'b0;
        chk("read_valid", read_valid, 16'h0001);
        chk("read_data", read_data, exp);
        tick(1);
    endtask : rd

    task automatic poll(input logic [7:0] exp);
        int n;
        poll_go = 1'b1;
        for (n = 0; n < 20 && poll_done !== 1'b1; n++)
            tick(1);
        if (n == 20)
        begin
            fail_count++;
            complete_run();
        end
        poll_go = 1'b0;
        chk("poll byte", got, exp);
        tick(1);
    endtask : poll

    initial
    begin
        tick(5);
        nrst = 1'b1;
        rd(SEL_ESR, 16'h0080);
        rd(SEL_ESR, 16'h0000);
        rd(4'hf, 16'h0000);
        wr(SEL_SRE, 16'h00ff);
        rd(SEL_SRE, 16'h00ff);
        wr(SEL_SRE, 16'h0024);
        clear_status = 1'b1;
        status_preset = 1'b1;
        tick(1);
        clear_status = 1'b0;
        status_preset = 1'b0;
        rd(SEL_SRE, 16'h0024);
        wr(SEL_SRE, 16'h0000);
        rd(SEL_SRE, 16'h0000);
        $display("test register access done");
        for (int i = 0; i < 22; i++)
        begin
            ev[i] = 1'b1;
            tick(1);
            ev[i] = 1'b0;
            tick(4);
            esel = i < 8 ? SEL_ESR : i < 11 ? SEL_OPER_EV : i < 20 ? SEL_MEAS_EV : SEL_QUES_EV;
            eexp = (16'h0001 << pos[i]) | (i == 21 ? QU_STICKY : EV_ZERO);
            rd(esel, eexp);
        end
        rd(SEL_QUES_EV, 16'h0100);
        ev[18] = 1'b1;
        tick(1);
        ev[18] = 1'b0;
        clear_status = 1'b1;
        tick(1);
        clear_status = 1'b0;
        rd(SEL_MEAS_EV, 16'h0000);
        rd(SEL_QUES_EV, 16'h0100);
        calibration_passed = 1'b1;
        tick(1);
        calibration_passed = 1'b0;
        rd(SEL_QUES_EV, 16'h0000);
        $display("test event bits done");
        wr(SEL_MEAS_EN, 16'h1000);
        wr(SEL_SRE, 16'h0001);
        ev[18] = 1'b1;
        tick(1);
        ev[18] = 1'b0;
        tick(3);
        chk("status_byte", status_byte, 16'h0041);
        rd(SEL_MEAS_EV, 16'h1000);
        tick(2);
        chk("status_byte", status_byte, 16'h0000);
        chk("service_request", service_request, 16'h0001);
        poll(8'h40);
        wr(SEL_SRE, 16'h0004);
        error_available = 1'b1;
        tick(3);
        chk("status_byte", status_byte, 16'h0044);
        poll(8'h44);
        chk("service_request", service_request, 16'h0000);
        chk("status_byte", status_byte, 16'h0044);
        poll(8'h04);
        error_available = 1'b0;
        tick(3);
        error_available = 1'b1;
        tick(3);
        poll(8'h44);
        error_available = 1'b0;
        tick(3);
        chk("status_byte", status_byte, 16'h0000);
        $display("test serial poll done");
        complete_run();
    end
endmodule : tb_status_service_request_unit
